//--- design/ufc_pkg.sv
package ufc_pkg;

    // ==========================================================
    // Clocking and rate limits
    localparam int CLK_HZ = 25_000_000;
    localparam int DEF_BAUD = 9600;
    localparam int MIN_BAUD = 183;
    localparam int MIN_BIT_CYCLES = 8;
    localparam int DIV_W = 18;
    localparam logic [DIV_W-1:0] MIN_DIV = DIV_W'(MIN_BIT_CYCLES);
    localparam logic [DIV_W-1:0] MAX_DIV = DIV_W'(CLK_HZ / MIN_BAUD);
    localparam logic [DIV_W-1:0] DEF_DIV = DIV_W'((CLK_HZ + DEF_BAUD / 2) / DEF_BAUD);

    // ==========================================================
    // Format reset values
    localparam logic DEF_DATA7 = 1'b0;
    localparam logic DEF_PAR_EN = 1'b0;
    localparam logic DEF_PAR_ODD = 1'b0;
    localparam logic DEF_STOP2 = 1'b0;
    localparam logic DEF_FLOW_EN = 1'b1;
    localparam logic DEF_DTR = 1'b0;
    localparam logic DEF_RI_WAKE = 1'b0;

    // ==========================================================
    // Frame layout
    localparam int DATA_W = 8;
    localparam logic [2:0] LAST_BIT7 = 3'h6;
    localparam logic [2:0] LAST_BIT8 = 3'h7;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_TRAIL
    } ufc_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } ufc_rx_state_t;

endpackage : ufc_pkg

//--- design/ufc_rx_if.sv
`timescale 1ns/10ps
// ==========================================================
// Receiver link between top and receiver
interface ufc_rx_if import ufc_pkg::*; ();
    logic [DIV_W-1:0] div;
    logic data7;
    logic par_en;
    logic par_odd;
    logic [DATA_W-1:0] data;
    logic valid;
    logic ack;
    logic frame_err;
    logic parity_err;
    logic overrun;

    modport rx (
        input div, data7, par_en, par_odd, ack,
        output data, valid, frame_err, parity_err, overrun
    );
    modport host (
        output div, data7, par_en, par_odd, ack,
        input data, valid, frame_err, parity_err, overrun
    );
endinterface : ufc_rx_if

//--- design/ufc_fifo.sv
`timescale 1ns/10ps
// ==========================================================
// Transmit data buffer
module ufc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic next_in_ready;
    logic push, pop;

    // Pointer and level update; ready kept in a flop so it is glitch free
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        next_in_ready = (next_count != FULL_CNT);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
        end
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

endmodule : ufc_fifo

//--- design/ufc_rx.sv
`timescale 1ns/10ps
// ==========================================================
// Serial receiver
module ufc_rx import ufc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial input pin
    input wire logic rxd,
    // Link to top
    ufc_rx_if.rx rif
);
    ufc_rx_state_t state, next_state;
    logic rxd_m, rxd_s;
    logic [DIV_W-1:0] cnt, next_cnt;
    logic [2:0] bitn, next_bitn;
    logic [DATA_W-1:0] sh, next_sh;
    logic par_acc, next_par_acc;
    logic perr, next_perr;
    logic [DATA_W-1:0] next_data;
    logic next_valid, next_frame_err, next_parity_err, next_overrun;
    logic bit_end;
    logic [2:0] last_bit;

    // Two-flop synchroniser on the pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxd_m <= 1'b1;
            rxd_s <= 1'b1;
        end else begin
            rxd_m <= rxd;
            rxd_s <= rxd_m;
        end
    end

    // Frame sampling at mid-bit
    always_comb begin
        bit_end = (cnt == '0);
        last_bit = rif.data7 ? LAST_BIT7 : LAST_BIT8;
        next_state = state;
        next_cnt = bit_end ? cnt : cnt - 1'b1;
        next_bitn = bitn;
        next_sh = sh;
        next_par_acc = par_acc;
        next_perr = perr;
        next_data = rif.data;
        next_valid = rif.valid && !rif.ack;
        next_frame_err = rif.frame_err;
        next_parity_err = rif.parity_err;
        next_overrun = rif.overrun;
        case (state)
            RX_IDLE: begin
                if (!rxd_s) begin
                    next_state = RX_START;
                    next_cnt = (rif.div >> 1) - 1'b1;
                end
            end
            RX_START: begin
                if (bit_end) begin
                    // A glitch shorter than half a bit is not a start
                    next_state = rxd_s ? RX_IDLE : RX_DATA;
                    next_cnt = rif.div - 1'b1;
                    next_bitn = '0;
                    next_par_acc = 1'b0;
                end
            end
            RX_DATA: begin
                if (bit_end) begin
                    next_sh = {rxd_s, sh[DATA_W-1:1]};
                    next_par_acc = par_acc ^ rxd_s;
                    next_bitn = bitn + 1'b1;
                    next_cnt = rif.div - 1'b1;
                    if (bitn == last_bit) begin
                        if (rif.data7) begin
                            next_sh = {1'b0, rxd_s, sh[DATA_W-1:2]};
                        end
                        next_state = rif.par_en ? RX_PARITY : RX_STOP;
                        next_perr = 1'b0;
                    end
                end
            end
            RX_PARITY: begin
                if (bit_end) begin
                    next_perr = rxd_s != (par_acc ^ rif.par_odd);
                    next_cnt = rif.div - 1'b1;
                    next_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (bit_end) begin
                    // Only the first stop bit is checked; resync on the next edge
                    next_state = RX_IDLE;
                    if (rif.valid && !rif.ack) begin
                        next_overrun = 1'b1;
                    end else begin
                        next_data = sh;
                        next_valid = 1'b1;
                        next_frame_err = !rxd_s;
                        next_parity_err = perr;
                        next_overrun = 1'b0;
                    end
                end
            end
            default: begin
                next_state = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= RX_IDLE;
            cnt <= '0;
            bitn <= '0;
            sh <= '0;
            par_acc <= 1'b0;
            perr <= 1'b0;
            rif.data <= '0;
            rif.valid <= 1'b0;
            rif.frame_err <= 1'b0;
            rif.parity_err <= 1'b0;
            rif.overrun <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            bitn <= next_bitn;
            sh <= next_sh;
            par_acc <= next_par_acc;
            perr <= next_perr;
            rif.data <= next_data;
            rif.valid <= next_valid;
            rif.frame_err <= next_frame_err;
            rif.parity_err <= next_parity_err;
            rif.overrun <= next_overrun;
        end
    end

endmodule : ufc_rx

//--- design/ufc_top.sv
`timescale 1ns/10ps
// ==========================================================
// Asynchronous serial port with modem handshake lines
module ufc_top import ufc_pkg::*; #(
    parameter int FIFO_W = DATA_W,
    parameter int FIFO_D = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration from processor
    input wire logic cfg_wr,
    input wire logic [DIV_W-1:0] cfg_baud_div,
    input wire logic cfg_data7,
    input wire logic cfg_par_en,
    input wire logic cfg_par_odd,
    input wire logic cfg_stop2,
    input wire logic cfg_flow_en,
    input wire logic cfg_dtr_on,
    input wire logic cfg_ri_wake_en,
    // Transmit data
    input wire logic [FIFO_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Receive data
    output logic [DATA_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_frame_err,
    output logic rx_parity_err,
    output logic rx_overrun,
    // Status
    output logic carrier,
    output logic wake_req,
    output logic [DIV_W-1:0] baud_div,
    // Serial and modem pins
    output logic txd,
    input wire logic rxd,
    output logic tx_active,
    output logic rts_n,
    input wire logic cts_n,
    output logic dtr_n,
    input wire logic dcd_n,
    input wire logic ring_indicate_n
);
    // ==========================================================
    // Configuration registers
    logic data7, par_en, par_odd, stop2, flow_en, dtr_on, ri_wake_en;
    logic next_data7, next_par_en, next_par_odd, next_stop2, next_flow_en, next_dtr_on, next_ri_wake_en;
    logic [DIV_W-1:0] next_baud_div;

    // Writes accepted any time; transmitter snapshots format per frame
    always_comb begin
        next_baud_div = baud_div;
        next_data7 = data7;
        next_par_en = par_en;
        next_par_odd = par_odd;
        next_stop2 = stop2;
        next_flow_en = flow_en;
        next_dtr_on = dtr_on;
        next_ri_wake_en = ri_wake_en;
        if (cfg_wr) begin
            if (cfg_baud_div < MIN_DIV) begin
                next_baud_div = MIN_DIV;
            end else if (cfg_baud_div > MAX_DIV) begin
                next_baud_div = MAX_DIV;
            end else begin
                next_baud_div = cfg_baud_div;
            end
            next_data7 = cfg_data7;
            next_par_en = cfg_par_en;
            next_par_odd = cfg_par_odd;
            next_stop2 = cfg_stop2;
            next_flow_en = cfg_flow_en;
            next_dtr_on = cfg_dtr_on;
            next_ri_wake_en = cfg_ri_wake_en;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baud_div <= DEF_DIV;
            data7 <= DEF_DATA7;
            par_en <= DEF_PAR_EN;
            par_odd <= DEF_PAR_ODD;
            stop2 <= DEF_STOP2;
            flow_en <= DEF_FLOW_EN;
            dtr_on <= DEF_DTR;
            ri_wake_en <= DEF_RI_WAKE;
        end else begin
            baud_div <= next_baud_div;
            data7 <= next_data7;
            par_en <= next_par_en;
            par_odd <= next_par_odd;
            stop2 <= next_stop2;
            flow_en <= next_flow_en;
            dtr_on <= next_dtr_on;
            ri_wake_en <= next_ri_wake_en;
        end
    end

    // ==========================================================
    // Modem lines
    logic cts_m, cts_s, dcd_m, dcd_s, ri_m, ri_s, ri_d;
    logic next_rts_n, next_dtr_n, next_carrier, next_wake_req;

    always_comb begin
        // Busy holding register means no room for another character
        next_rts_n = flow_en ? rx_valid : 1'b0;
        next_dtr_n = !dtr_on;
        next_carrier = !dcd_s;
        next_wake_req = ri_wake_en && ri_d && !ri_s;
    end

    // Pins pass two flops before any logic looks at them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cts_m <= 1'b1;
            cts_s <= 1'b1;
            dcd_m <= 1'b1;
            dcd_s <= 1'b1;
            ri_m <= 1'b1;
            ri_s <= 1'b1;
            ri_d <= 1'b1;
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            carrier <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            cts_m <= cts_n;
            cts_s <= cts_m;
            dcd_m <= dcd_n;
            dcd_s <= dcd_m;
            ri_m <= ring_indicate_n;
            ri_s <= ri_m;
            ri_d <= ri_s;
            rts_n <= next_rts_n;
            dtr_n <= next_dtr_n;
            carrier <= next_carrier;
            wake_req <= next_wake_req;
        end
    end

    // ==========================================================
    // Receiver
    ufc_rx_if rif ();

    assign rif.div = baud_div;
    assign rif.data7 = data7;
    assign rif.par_en = par_en;
    assign rif.par_odd = par_odd;
    assign rif.ack = rx_ready;
    assign rx_data = rif.data;
    assign rx_valid = rif.valid;
    assign rx_frame_err = rif.frame_err;
    assign rx_parity_err = rif.parity_err;
    assign rx_overrun = rif.overrun;

    ufc_rx u_rx (
        .clk(clk),
        .rst(rst),
        .rxd(rxd),
        .rif(rif.rx)
    );

    // ==========================================================
    // Transmit buffer
    logic [FIFO_W-1:0] f_data;
    logic f_valid, f_pop;

    ufc_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );

    // ==========================================================
    // Transmitter
    ufc_tx_state_t state, next_state;
    logic [DIV_W-1:0] cnt, next_cnt;
    logic [2:0] bitn, next_bitn, last_bit, next_last_bit;
    logic [DATA_W-1:0] sh, next_sh;
    logic par_bit, next_par_bit, f_stop2, next_f_stop2, f_par_en, next_f_par_en;
    logic stop_done, next_stop_done;
    logic next_txd, next_tx_active, bit_end, cts_ok;
    logic [DATA_W-1:0] load_data;

    // Frame sequencer; format frozen at the start bit so a mid-frame write cannot tear it
    always_comb begin
        bit_end = (cnt == '0);
        cts_ok = !flow_en || !cts_s;
        load_data = data7 ? {1'b0, f_data[DATA_W-2:0]} : f_data[DATA_W-1:0];
        next_state = state;
        next_cnt = bit_end ? cnt : cnt - 1'b1;
        next_bitn = bitn;
        next_last_bit = last_bit;
        next_sh = sh;
        next_par_bit = par_bit;
        next_f_stop2 = f_stop2;
        next_f_par_en = f_par_en;
        next_stop_done = stop_done;
        next_txd = txd;
        next_tx_active = tx_active;
        f_pop = 1'b0;
        case (state)
            TX_IDLE: begin
                next_txd = 1'b1;
                if (f_valid && cts_ok) begin
                    next_state = TX_LEAD;
                    next_tx_active = 1'b1;
                    next_cnt = baud_div - 1'b1;
                end
            end
            TX_LEAD: begin
                if (bit_end) begin
                    next_state = TX_START;
                end
            end
            TX_START: begin
                if (bit_end) begin
                    next_state = TX_DATA;
                    next_bitn = '0;
                    next_cnt = baud_div - 1'b1;
                    next_txd = sh[0];
                end
            end
            TX_STOP: begin
                if (bit_end) begin
                    next_stop_done = 1'b1;
                    if (f_stop2 && !stop_done) begin
                        next_cnt = baud_div - 1'b1;
                    end else if (f_valid && cts_ok) begin
                        next_state = TX_START; // back to back, no idle gap
                    end else begin
                        next_state = TX_TRAIL;
                        next_cnt = baud_div - 1'b1;
                    end
                end
            end
            TX_DATA: begin
                if (bit_end) begin
                    next_cnt = baud_div - 1'b1;
                    next_sh = {1'b0, sh[DATA_W-1:1]};
                    next_bitn = bitn + 1'b1;
                    next_txd = sh[1];
                    if (bitn == last_bit) begin
                        next_state = f_par_en ? TX_PARITY : TX_STOP;
                        next_txd = f_par_en ? par_bit : 1'b1;
                        next_stop_done = 1'b0;
                    end
                end
            end
            TX_PARITY: begin
                if (bit_end) begin
                    next_cnt = baud_div - 1'b1;
                    next_state = TX_STOP;
                    next_txd = 1'b1;
                end
            end
            TX_TRAIL: begin
                if (bit_end) begin
                    next_state = TX_IDLE;
                    next_tx_active = 1'b0;
                end
            end
            default: begin
                next_state = TX_IDLE;
            end
        endcase
        // Start bit shared by the lead-in and back-to-back paths
        if (next_state == TX_START && state != TX_START) begin
            f_pop = 1'b1;
            next_txd = 1'b0;
            next_cnt = baud_div - 1'b1;
            next_sh = load_data;
            next_par_bit = (^load_data) ^ par_odd;
            next_last_bit = data7 ? LAST_BIT7 : LAST_BIT8;
            next_f_stop2 = stop2;
            next_f_par_en = par_en;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TX_IDLE;
            cnt <= '0;
            bitn <= '0;
            last_bit <= LAST_BIT8;
            sh <= '0;
            par_bit <= 1'b0;
            f_stop2 <= DEF_STOP2;
            f_par_en <= DEF_PAR_EN;
            stop_done <= 1'b0;
            txd <= 1'b1;
            tx_active <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            bitn <= next_bitn;
            last_bit <= next_last_bit;
            sh <= next_sh;
            par_bit <= next_par_bit;
            f_stop2 <= next_f_stop2;
            f_par_en <= next_f_par_en;
            stop_done <= next_stop_done;
            txd <= next_txd;
            tx_active <= next_tx_active;
        end
    end

endmodule : ufc_top

//--- tb/ufc_top_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker, flow control held on by the bench
module ufc_top_monitor import ufc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire logic cfg_wr,
    input wire logic [DIV_W-1:0] cfg_baud_div,
    input wire logic cfg_dtr_on,
    input wire logic rx_ready,
    input wire logic dcd_n,
    // Outputs
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic wake_req,
    input wire logic carrier,
    input wire logic [DIV_W-1:0] baud_div,
    input wire logic txd,
    input wire logic tx_active,
    input wire logic rts_n,
    input wire logic dtr_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Lead bit; only valid for the eight-cycle bit the bench uses
    sequence s_lead;
        txd [*8] ##1 !txd;
    endsequence
    chk_tx_lead: assert property ($rose(tx_active) |-> s_lead) else $error("bad lead");
    chk_idle_high: assert property (!tx_active |-> txd) else $error("txd low idle");
    chk_div_clamp: assert property (cfg_wr && cfg_baud_div < MIN_DIV |=> baud_div == MIN_DIV)
        else $error("no clamp");
    chk_dtr_set: assert property (cfg_wr |-> ##2 dtr_n == !$past(cfg_dtr_on, 2)) else $error("dtr");
    chk_rts_busy: assert property ($rose(rx_valid) |=> rts_n) else $error("rts low");
    chk_rx_held: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("rx lost");
    chk_carrier_lvl: assert property ($stable(dcd_n) [*4] |-> carrier != dcd_n) else $error("dcd");
    chk_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake long");
endmodule : ufc_top_monitor
bind ufc_top ufc_top_monitor u_ufc_top_monitor (.clk, .rst, .cfg_wr, .cfg_baud_div, .cfg_dtr_on, .rx_ready,
    .dcd_n, .rx_data, .rx_valid, .wake_req, .carrier, .baud_div, .txd, .tx_active, .rts_n, .dtr_n);

//--- tb/ufc_remote.sv
`timescale 1ns/10ps
// ==========================================================
// Far-end serial device, eight clocks per bit
module ufc_remote (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic txd,
    output logic rxd,
    output logic cts_n
);
    int nb = 8;
    logic pe = 1'h0;
    logic po = 1'h0;
    logic s2 = 1'h0;
    logic [9:0] got[$];
    // Idle line high, clear to send
    initial begin
        rxd = 1'h1;
        cts_n = 1'h0;
    end
    // One bit held for a whole bit period
    task automatic bit_out(input logic b);
        rxd <= b;
        repeat (8) @(posedge clk);
    endtask : bit_out
    // Frame out; stop or parity broken on request
    task automatic send(input logic [7:0] d, input logic bad_stop, input logic bad_par);
        logic x;
        x = po;
        @(posedge clk);
        bit_out(1'h0);
        for (int i = 0; i < nb; i++) begin
            bit_out(d[i]);
            x ^= d[i];
        end
        if (pe) bit_out(x ^ bad_par);
        bit_out(!bad_stop);
        if (s2) bit_out(1'h1);
        bit_out(1'h1);
    endtask : send
    // Mid-bit decode; word is parity error, framing error, data
    always begin : decode
        logic [7:0] d;
        logic x;
        logic e;
        @(negedge txd);
        repeat (4) @(posedge clk);
        e = txd;
        d = 8'h00;
        x = po;
        for (int i = 0; i < nb; i++) begin
            repeat (8) @(posedge clk);
            d[i] = txd;
            x ^= txd;
        end
        if (pe) begin
            repeat (8) @(posedge clk);
            x ^= txd;
        end else x = 1'h0;
        repeat (8) @(posedge clk);
        e |= !txd;
        if (s2) begin
            repeat (8) @(posedge clk);
            e |= !txd;
        end
        got.push_back({x, e, d});
    end
endmodule : ufc_remote

//--- tb/ufc_top_bench.sv
`timescale 1ns/10ps
// ==========================================================
// Bench; inputs change at the rising edge
module ufc_top_bench import ufc_pkg::*; ;
    logic clk = 1'h0, rst = 1'h1, cfg_wr = 1'h0, tx_valid = 1'h0, rx_ready = 1'h0;
    logic cfg_data7 = 1'h0, cfg_par_en = 1'h0, cfg_par_odd = 1'h0, cfg_stop2 = 1'h0;
    logic dcd_n = 1'h1, ring_indicate_n = 1'h1, cfg_dtr_on = 1'h1;
    logic [DIV_W-1:0] cfg_baud_div = DEF_DIV;
    logic [7:0] tx_data = 8'h00;
    logic tx_ready, rx_valid, rx_frame_err, rx_parity_err, rx_overrun, carrier, wake_req;
    logic txd, rxd, tx_active, rts_n, cts_n, dtr_n;
    logic [DATA_W-1:0] rx_data;
    logic [DIV_W-1:0] baud_div;
    int bad_count = 0, n_tests = 0;
    ufc_top u_ufc_top (.clk, .rst, .cfg_wr, .cfg_baud_div, .cfg_data7, .cfg_par_en, .cfg_par_odd, .cfg_stop2,
        .cfg_flow_en(1'h1), .cfg_dtr_on, .cfg_ri_wake_en(1'h1), .tx_data, .tx_valid, .tx_ready, .rx_data,
        .rx_valid, .rx_ready, .rx_frame_err, .rx_parity_err, .rx_overrun, .carrier, .wake_req, .baud_div,
        .txd, .rxd, .tx_active, .rts_n, .cts_n, .dtr_n, .dcd_n, .ring_indicate_n);
    ufc_remote u_ufc_remote (.clk, .txd, .rxd, .cts_n);
    always #20 clk = ~clk;
    // ==========================================================
    // Verdict and compare
    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [17:0] a, input logic [17:0] e);
        n_tests++;
        if (a !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, a, e);
        end
    endtask : chk
    // A wait that ran out ends the run
    task automatic hang;
        chk(18'h0, 18'h1);
        stop_test();
    endtask : hang
    // Config strobe; far end follows the same format
    task automatic cfg(input logic [DIV_W-1:0] dv, input logic [3:0] f);
        @(posedge clk);
        cfg_wr <= 1'h1;
        cfg_baud_div <= dv;
        {cfg_data7, cfg_par_en, cfg_par_odd, cfg_stop2} <= f;
        u_ufc_remote.nb = f[3] ? 7 : 8;
        {u_ufc_remote.pe, u_ufc_remote.po, u_ufc_remote.s2} = f[2:0];
        @(posedge clk);
        cfg_wr <= 1'h0;
        @(negedge clk);
    endtask : cfg
    // Valid held until ready seen at the taking edge
    task automatic send_bytes(input logic [7:0] q[$]);
        int k;
        @(posedge clk);
        foreach (q[i]) begin
            tx_data <= q[i];
            tx_valid <= 1'h1;
            @(negedge clk);
            for (k = 0; k < 9000 && tx_ready !== 1'h1; k++) @(negedge clk);
            if (k == 9000) hang();
            @(posedge clk);
        end
        tx_valid <= 1'h0;
    endtask : send_bytes
    task automatic expect_tx(input logic [7:0] d, input logic d7);
        int k;
        for (k = 0; k < 3000 && u_ufc_remote.got.size() == 0; k++) @(posedge clk);
        if (k == 3000) hang();
        chk(18'(u_ufc_remote.got.pop_front()), 18'({2'h0, ~d7 & d[7], d[6:0]}));
    endtask : expect_tx
    // Received word, busy flag, then one-cycle acknowledge
    task automatic expect_rx(input logic [9:0] e);
        int k;
        for (k = 0; k < 3000 && rx_valid !== 1'h1; k++) @(negedge clk);
        if (k == 3000) hang();
        @(negedge clk);
        chk(18'({rx_parity_err, rx_frame_err, rx_data}), 18'(e));
        chk(18'(rts_n), 18'h1);
        @(posedge clk);
        rx_ready <= 1'h1;
        @(posedge clk);
        rx_ready <= 1'h0;
    endtask : expect_rx
    // ==========================================================
    // Main sequence
    initial begin : main
        logic [7:0] q[$];
        logic [3:0] fm[4];
        int k;
        fm = '{4'h0, 4'hC, 4'h7, 4'h9};
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(negedge clk);
        chk(baud_div, DEF_DIV);
        chk(18'({rts_n, dtr_n, tx_active, txd}), 18'h5);
        cfg(18'h4, 4'h0);
        chk(baud_div, MIN_DIV);
        @(negedge clk);
        chk(18'(dtr_n), 18'h0);
        foreach (fm[i]) begin
            cfg(18'h8, fm[i]);
            send_bytes('{8'hB5, 8'h3C});
            expect_tx(8'hB5, fm[i][3]);
            expect_tx(8'h3C, fm[i][3]);
            u_ufc_remote.send(8'hA6, 1'h0, 1'h0);
            expect_rx(10'(fm[i][3] ? 8'h26 : 8'hA6));
        end
        cfg(18'h8, 4'h6);
        u_ufc_remote.send(8'h5A, 1'h0, 1'h1);
        expect_rx(10'h25A);
        u_ufc_remote.send(8'h5A, 1'h1, 1'h0);
        expect_rx(10'h15A);
        u_ufc_remote.send(8'h11, 1'h0, 1'h0);
        u_ufc_remote.send(8'h22, 1'h0, 1'h0);
        chk(18'({rx_overrun, rx_data}), 18'h111);
        expect_rx(10'h011);
        // Remote holds off; fill the buffer until it refuses
        @(posedge clk);
        u_ufc_remote.cts_n <= 1'h1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) q.push_back(8'(i * 37));
        send_bytes(q);
        repeat (2) @(negedge clk);
        chk(18'({tx_ready, tx_active}), 18'h0);
        @(posedge clk);
        u_ufc_remote.cts_n <= 1'h0;
        foreach (q[i]) expect_tx(q[i], 1'h0);
        @(posedge clk);
        dcd_n <= 1'h0;
        ring_indicate_n <= 1'h0;
        k = 0;
        repeat (10) begin
            @(negedge clk);
            if (wake_req === 1'h1) k++;
        end
        chk(18'(carrier), 18'h1);
        chk(18'(k), 18'h1);
        @(posedge clk);
        cfg_dtr_on <= 1'h0;
        cfg(18'h8, 4'h6);
        @(negedge clk);
        chk(18'(dtr_n), 18'h1);
        stop_test();
    end
endmodule : ufc_top_bench
